//--- hdl/omarb_core.sv
/*
 Operation mode arbiter with APB register slave.
 Assumes pins are asynchronous; stop status comes from pins too.
*/
// Summary of operation
// RULE1 - Settings 0/2/6 allow comms switching when stopped
// RULE2 - Startup 10: panel-comms on panel, off comms
// RULE3 - User assigns codes 65/66 to terminals
// RULE4 - Settings 1,2,3/4 fix mode under startup 10
// RULE5 - Setting 7: interlock off forces external
// RULE6 - External-comms on overrides panel to comms
// RULE7 - Panel-comms off: follow panel-external input
// RULE8 - Startup 0/1: external-comms picks comms/external
// RULE9 - Setting 7: external-comms only with interlock
// RULE10 - Setting 2 toggles comms/external, never panel
// RULE11 - External chosen: panel-comms else panel-external
// RULE12 - Priority: setting, interlock, switches, startup
// RULE13 - Startup 0 per setting, 1/10 comms
// RULE14 - Startup choice applied at power-on, restoration
// RULE15 - Mode setting accepts 0-4,6,7; resets 0
// RULE16 - Settings writable only during stop
// RULE17 - Settings writable only if display setting 0
// RULE18 - Commit change only when stopped, except 6; code also commits at once under setting 7 with interlock off
`include "omarb_regs.svh"
module omarb_core
	import omarb_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Terminal and panel pins
	input wire logic panel_comms_switch_in,
	input wire logic external_comms_switch_in,
	input wire logic panel_external_switch_in,
	input wire logic panel_interlock_in,
	input wire logic motor_stopped_in,
	input wire logic power_restore_in,
	// Mode outputs
	output logic [3:0] mode_out,
	output logic output_halt_out
);

	// ----------------------------------------
	// Settings and state
	// ----------------------------------------
	logic [7:0] mode_sel_reg;
	logic [7:0] startup_sel_reg;
	logic [7:0] ext_display_reg;
	logic [1:0] assign_reg;
	omarb_mode_t mode_reg, mode_next;
	logic [31:0] prdata_next;
	logic [4:0] pins_sync;
	omarb_switch_t sw;
	logic stopped;
	logic restore_d_reg;

	omarb_sync #(.WIDTH(5)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in({panel_comms_switch_in, external_comms_switch_in,
			panel_external_switch_in, panel_interlock_in,
			power_restore_in}),
		.sync_out(pins_sync)
	);

	assign sw = omarb_switch_t'(pins_sync[4:1]);

	// The motor status pin is sampled once per cycle here too
	logic [1:0] stop_sync_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stop_sync_reg <= 2'h0;
		else
			stop_sync_reg <= {stop_sync_reg[0], motor_stopped_in};
	end
	assign stopped = stop_sync_reg[1];

	function automatic logic valid_sel(input logic [7:0] v);
		valid_sel = (v <= `OMARB_SEL_4) || (v == `OMARB_SEL_6) ||
			(v == `OMARB_SEL_7); // RULE15
	endfunction

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire wr_acc = psel && penable && pwrite;
	// Read data loads in setup so it stands through the access cycle
	wire rd_setup = psel && !penable && !pwrite;
	wire hit_mode = paddr == `OMARB_OFS_MODE_SEL;
	wire hit_su = paddr == `OMARB_OFS_STARTUP_SEL;
	wire hit_disp = paddr == `OMARB_OFS_EXT_DISPLAY;
	wire hit_asg = paddr == `OMARB_OFS_TERM_ASSIGN;
	wire hit_st = paddr == `OMARB_OFS_STATUS;
	// Settings only while stopped and extended display is 0
	wire set_ok = stopped && (ext_display_reg == 8'h00); // RULE16 RULE17
	wire wr_mode = wr_acc && hit_mode && set_ok &&
		valid_sel(pwdata[7:0]); // RULE15
	wire wr_su = wr_acc && hit_su && set_ok &&
		(pwdata[7:0] == `OMARB_SU_0 || pwdata[7:0] == `OMARB_SU_1 ||
		pwdata[7:0] == `OMARB_SU_10);

	// ----------------------------------------
	// Mode arbitration
	// ----------------------------------------
	// Assignment bit 1: panel-comms wired; bit 0: external-comms wired
	wire pc_used = assign_reg[1]; // RULE3
	wire ec_used = assign_reg[0]; // RULE3
	wire su10 = startup_sel_reg == `OMARB_SU_10;
	wire m7 = mode_sel_reg == `OMARB_SEL_7;
	wire m6 = mode_sel_reg == `OMARB_SEL_6;
	wire ec_on = ec_used && sw.external_comms;
	wire lock_ok = !m7 || sw.panel_interlock; // RULE9
	omarb_mode_t ext_or_panel_mode;
	assign ext_or_panel_mode = sw.panel_external ? OMARB_EXTERNAL :
		OMARB_LOCAL_PANEL;

	omarb_mode_t target;
	omarb_mode_t pc_pick, ec_pick;
	always_comb
	begin
		// Panel-comms path, external-comms overrides panel choice
		if (sw.panel_comms)
			pc_pick = ec_on ? OMARB_COMMUNICATION : OMARB_LOCAL_PANEL; // RULE6
		else
			pc_pick = omarb_mode_t'(ext_or_panel_mode); // RULE7
		// External-comms path, then panel-comms, then panel-external
		if (ec_on && lock_ok)
			ec_pick = OMARB_COMMUNICATION; // RULE8
		else if (mode_sel_reg == `OMARB_SEL_2)
			ec_pick = OMARB_EXTERNAL; // RULE10
		else if (pc_used)
			ec_pick = sw.panel_comms ? OMARB_LOCAL_PANEL :
				OMARB_COMMUNICATION; // RULE11
		else
			ec_pick = omarb_mode_t'(ext_or_panel_mode); // RULE11
		// Setting first, interlock second, switches after
		case (mode_sel_reg) // RULE12
			`OMARB_SEL_1: target = OMARB_LOCAL_PANEL; // RULE4
			`OMARB_SEL_3,
			`OMARB_SEL_4: target = OMARB_COMBINED; // RULE4
			`OMARB_SEL_2:
				target = su10 ? OMARB_COMMUNICATION : ec_pick; // RULE4
			`OMARB_SEL_7:
				if (!sw.panel_interlock)
					target = OMARB_EXTERNAL; // RULE5
				else
					target = ec_pick;
			default:
				if (su10 && pc_used)
					target = sw.panel_comms ? pc_pick :
						OMARB_COMMUNICATION; // RULE2
				else if (su10)
					target = mode_reg;
				else
					target = ec_pick;
		endcase
	end

	// Start-up choice for power-on and power restoration
	omarb_mode_t startup_mode;
	always_comb
	begin
		case (mode_sel_reg) // RULE13
			`OMARB_SEL_1: startup_mode = OMARB_LOCAL_PANEL;
			`OMARB_SEL_3,
			`OMARB_SEL_4: startup_mode = OMARB_COMBINED;
			`OMARB_SEL_7:
				startup_mode = (startup_sel_reg == `OMARB_SU_1 &&
					sw.panel_interlock) ? OMARB_COMMUNICATION :
					OMARB_EXTERNAL;
			default:
				startup_mode = (startup_sel_reg == `OMARB_SU_0) ?
					OMARB_EXTERNAL : OMARB_COMMUNICATION;
		endcase
	end

	wire restore_edge = pins_sync[0] && !restore_d_reg;
	// Forced external under interlock loss acts at once
	wire forced = m7 && !sw.panel_interlock;
	// Settings 0/2/6 change only when stopped; 6 also while running
	wire commit_ok = stopped || m6 || forced; // RULE1 RULE18

	always_comb
	begin
		if (restore_edge)
			mode_next = startup_mode; // RULE14
		else if (commit_ok)
			mode_next = target;
		else
			mode_next = mode_reg;
	end

	// Under setting 7, output halts in external mode while the interlock is on
	wire halt_next = m7 && sw.panel_interlock &&
		mode_next == OMARB_EXTERNAL; // RULE5

	always_comb
	begin
		prdata_next = 32'h0;
		if (hit_mode)
			prdata_next[7:0] = mode_sel_reg;
		if (hit_su)
			prdata_next[7:0] = startup_sel_reg;
		if (hit_disp)
			prdata_next[7:0] = ext_display_reg;
		if (hit_asg)
			prdata_next[1:0] = assign_reg;
		if (hit_st)
			prdata_next = {26'h0, output_halt_out, 1'b0, mode_reg};
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Reset applies the start-up choice after release; the mode
	// begins external and is reloaded on the first cycle.
	logic boot_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_sel_reg <= `OMARB_RST_MODE_SEL; // RULE15
			startup_sel_reg <= `OMARB_RST_STARTUP_SEL; // RULE13
			ext_display_reg <= `OMARB_RST_EXT_DISPLAY;
			assign_reg <= 2'h0;
			mode_reg <= OMARB_EXTERNAL;
			output_halt_out <= 1'b0;
			restore_d_reg <= 1'b0;
			boot_reg <= 1'b1;
		end
		else
		begin
			if (wr_mode)
				mode_sel_reg <= pwdata[7:0];
			if (wr_su)
				startup_sel_reg <= pwdata[7:0];
			if (wr_acc && hit_disp)
				ext_display_reg <= pwdata[7:0];
			if (wr_acc && hit_asg)
				assign_reg <= pwdata[1:0];
			boot_reg <= 1'b0;
			mode_reg <= boot_reg ? startup_mode : mode_next; // RULE14
			output_halt_out <= halt_next;
			restore_d_reg <= pins_sync[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			mode_out <= OMARB_EXTERNAL;
		end
		else
		begin
			prdata <= rd_setup ? prdata_next : prdata;
			pready <= psel && !penable;
			pslverr <= 1'b0;
			mode_out <= boot_reg ? startup_mode : mode_next;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	mode_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot(mode_reg)) else $error("mode not one-hot"); // RULE12
	fixed_panel_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_sel_reg == `OMARB_SEL_1 && !boot_reg && !restore_edge &&
		stopped) |=> mode_reg == OMARB_LOCAL_PANEL)
		else $error("setting 1 not panel"); // RULE4
	forced_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
		(m7 && !sw.panel_interlock && !boot_reg && !restore_edge) |=>
		mode_reg == OMARB_EXTERNAL) else $error("interlock not forcing");
		// RULE5
	sel_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode_sel_reg != 8'h05 && mode_sel_reg <= `OMARB_SEL_7)
		else $error("illegal mode setting"); // RULE15
	hold_run_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!stopped && !m6 && !forced && !restore_edge && !boot_reg) |=>
		$stable(mode_reg)) else $error("mode moved while running");
		// RULE18
	no_panel2_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_sel_reg == `OMARB_SEL_2 && !boot_reg && stopped) |=>
		mode_reg != OMARB_LOCAL_PANEL) else $error("panel under 2");
		// RULE10
	wr_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_mode && ext_display_reg != 8'h00) |=>
		$stable(mode_sel_reg)) else $error("write not locked"); // RULE17
	halt_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
		output_halt_out |-> mode_reg == OMARB_EXTERNAL)
		else $error("halt outside external"); // RULE5
	cv_comms: cover property (@(posedge pclk) disable iff (!presetn)
		mode_reg == OMARB_COMMUNICATION);
	cv_panel: cover property (@(posedge pclk) disable iff (!presetn)
		mode_reg == OMARB_LOCAL_PANEL);
	cv_halt: cover property (@(posedge pclk) disable iff (!presetn)
		output_halt_out);

endmodule

//--- hdl/omarb_regs.svh
/*
 Register offsets, field layouts, reset values and codes of the
 operation mode arbiter. Assumes inclusion by bare name.
*/
`ifndef OMARB_REGS_SVH
`define OMARB_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OMARB_OFS_MODE_SEL    12'h000
`define OMARB_OFS_STARTUP_SEL 12'h004
`define OMARB_OFS_EXT_DISPLAY 12'h008
`define OMARB_OFS_TERM_ASSIGN 12'h00c
`define OMARB_OFS_STATUS      12'h010

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OMARB_RST_MODE_SEL    8'h00
`define OMARB_RST_STARTUP_SEL 8'h00
`define OMARB_RST_EXT_DISPLAY 8'h00

// ----------------------------------------
// Setting codes
// ----------------------------------------
`define OMARB_SEL_0  8'h00
`define OMARB_SEL_1  8'h01
`define OMARB_SEL_2  8'h02
`define OMARB_SEL_3  8'h03
`define OMARB_SEL_4  8'h04
`define OMARB_SEL_6  8'h06
`define OMARB_SEL_7  8'h07
`define OMARB_SU_0   8'h00
`define OMARB_SU_1   8'h01
`define OMARB_SU_10  8'h0a
`define OMARB_FN_PANEL_COMMS 8'h41
`define OMARB_FN_EXT_COMMS   8'h42

// ----------------------------------------
// Status fields
// ----------------------------------------
`define OMARB_ST_MODE_LSB 0
`define OMARB_ST_HALT_BIT 5

`endif

//--- hdl/omarb_pkg.sv
/*
 Types of the operation mode arbiter.
 Assumes nothing of its surroundings.
*/
package omarb_pkg;

	// ----------------------------------------
	// One-hot operating modes
	// ----------------------------------------
	typedef enum logic [3:0] {
		OMARB_LOCAL_PANEL = 4'h1,
		OMARB_EXTERNAL = 4'h2,
		OMARB_COMBINED = 4'h4,
		OMARB_COMMUNICATION = 4'h8
	} omarb_mode_t;

	typedef struct packed {
		logic panel_comms;
		logic external_comms;
		logic panel_external;
		logic panel_interlock;
	} omarb_switch_t;

	typedef struct packed {
		logic [11:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
	} omarb_apb_req_t;

endpackage

//--- hdl/omarb_sync.sv
/*
 Two-flop synchroniser for a group of pin levels.
 Assumes the pins are asynchronous to pclk.
*/
module omarb_sync
	import omarb_pkg::*;
#(
	parameter int WIDTH = 5
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins and synchronised levels
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// ----------------------------------------
	// First flop feeds only the second
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= pin_in;
			sync_out <= meta_reg;
		end
	end

endmodule

//--- tb/omarb_term_model.sv
/*
 Terminal pins and operator panel as seen from outside the arbiter.
 Assumes the bench commands levels; pins follow at the next edge.
*/
module omarb_term_model
	import omarb_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Commanded levels
	input wire omarb_switch_t sw_cmd,
	input wire logic stop_cmd,
	input wire logic restore_cmd,
	// Pin levels
	output omarb_switch_t sw_pin,
	output logic stop_pin,
	output logic restore_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins move only just after an edge, never mid-cycle
	always_ff @(posedge pclk)
	begin
		sw_pin <= sw_cmd;
		stop_pin <= stop_cmd;
		restore_pin <= restore_cmd;
	end
endmodule

//--- tb/tb_operation_mode_arbiter.sv
/*
 Self-checking bench of the operation mode arbiter.
 Assumes an APB slave that answers in time and pins from the model.
*/
`include "omarb_regs.svh"
module tb_operation_mode_arbiter
	import omarb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [7:0] sel;
		logic [7:0] su;
		logic [31:0] asg;
		omarb_switch_t sw;
		logic [3:0] exp;
	} omarb_case_t;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic stop_cmd, restore_cmd, stop_pin, restore_pin, halt;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] mode;
	omarb_switch_t sw_cmd, sw_pin;
	int err_total, n_tests;
	omarb_case_t rows[14];

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end

	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	omarb_term_model i_term (.pclk(pclk), .sw_cmd(sw_cmd),
		.stop_cmd(stop_cmd), .restore_cmd(restore_cmd), .sw_pin(sw_pin),
		.stop_pin(stop_pin), .restore_pin(restore_pin));

	omarb_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.panel_comms_switch_in(sw_pin.panel_comms),
		.external_comms_switch_in(sw_pin.external_comms),
		.panel_external_switch_in(sw_pin.panel_external),
		.panel_interlock_in(sw_pin.panel_interlock),
		.motor_stopped_in(stop_pin), .power_restore_in(restore_pin),
		.mode_out(mode), .output_halt_out(halt));

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Waits as long as the slave needs; only the watchdog ends it
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'h1);
		rd = prdata;
		`CHK(pslverr, 1'h0)
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
		apb(1'h0, a, 32'h0);
		`CHK(rd[7:0], e)
	endtask

	// Pin path is model edge, two sync flops, then commit
	task automatic settle;
		repeat (8) @(posedge pclk);
	endtask

	task automatic chk_mode(input logic [3:0] e);
		apb(1'h0, `OMARB_OFS_STATUS, 32'h0);
		`CHK(rd[3:0], e)
		`CHK(mode, e)
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		sw_cmd = 4'h3;
		stop_cmd = 1'h1;
		restore_cmd = 1'h0;
		err_total = 0;
		n_tests = 0;
		rows = '{'{8'h0, 8'h0, 32'h1, 4'h6, 4'h8},
			'{8'h0, 8'h0, 32'h1, 4'h3, 4'h2},
			'{8'h0, 8'h0, 32'h1, 4'h1, 4'h1},
			'{8'h2, 8'h0, 32'h1, 4'h7, 4'h8},
			'{8'h2, 8'h0, 32'h1, 4'h1, 4'h2},
			'{8'h7, 8'h0, 32'h1, 4'h6, 4'h2},
			'{8'h7, 8'h0, 32'h1, 4'h7, 4'h8},
			'{8'h1, 8'ha, 32'h2, 4'h3, 4'h1},
			'{8'h2, 8'ha, 32'h2, 4'hb, 4'h8},
			'{8'h0, 8'ha, 32'h2, 4'hb, 4'h1},
			'{8'h0, 8'ha, 32'h3, 4'hf, 4'h8},
			'{8'h6, 8'ha, 32'h2, 4'hb, 4'h1},
			'{8'h3, 8'ha, 32'h2, 4'h3, 4'h4},
			'{8'h4, 8'ha, 32'h2, 4'h3, 4'h4}};
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		settle();
		chk_mode(4'h2);
		rdchk(`OMARB_OFS_MODE_SEL, `OMARB_RST_MODE_SEL);
		rdchk(`OMARB_OFS_STARTUP_SEL, `OMARB_RST_STARTUP_SEL);
		apb(1'h1, `OMARB_OFS_MODE_SEL, 32'h5);
		rdchk(`OMARB_OFS_MODE_SEL, 8'h0);
		apb(1'h1, `OMARB_OFS_EXT_DISPLAY, 32'h1);
		apb(1'h1, `OMARB_OFS_MODE_SEL, 32'h1);
		rdchk(`OMARB_OFS_MODE_SEL, 8'h0);
		apb(1'h1, `OMARB_OFS_EXT_DISPLAY, 32'h0);
		stop_cmd <= 1'h0;
		settle();
		apb(1'h1, `OMARB_OFS_MODE_SEL, 32'h1);
		rdchk(`OMARB_OFS_MODE_SEL, 8'h0);
		stop_cmd <= 1'h1;
		settle();
		$display("reset and refusal test done");
		foreach (rows[i])
		begin
			apb(1'h1, `OMARB_OFS_TERM_ASSIGN, rows[i].asg);
			apb(1'h1, `OMARB_OFS_STARTUP_SEL, {24'h0, rows[i].su});
			apb(1'h1, `OMARB_OFS_MODE_SEL, {24'h0, rows[i].sel});
			sw_cmd <= rows[i].sw;
			settle();
			chk_mode(rows[i].exp);
			$display("row %0d done", i);
		end
		apb(1'h1, `OMARB_OFS_TERM_ASSIGN, 32'h1);
		apb(1'h1, `OMARB_OFS_STARTUP_SEL, 32'h1);
		apb(1'h1, `OMARB_OFS_MODE_SEL, 32'h0);
		sw_cmd <= 4'h3;
		settle();
		chk_mode(4'h2);
		stop_cmd <= 1'h0;
		restore_cmd <= 1'h1;
		settle();
		chk_mode(4'h8);
		restore_cmd <= 1'h0;
		settle();
		chk_mode(4'h8);
		stop_cmd <= 1'h1;
		settle();
		chk_mode(4'h2);
		apb(1'h1, `OMARB_OFS_STARTUP_SEL, 32'h0);
		apb(1'h1, `OMARB_OFS_MODE_SEL, 32'h6);
		stop_cmd <= 1'h0;
		sw_cmd <= 4'h7;
		settle();
		chk_mode(4'h8);
		stop_cmd <= 1'h1;
		settle();
		apb(1'h1, `OMARB_OFS_MODE_SEL, 32'h7);
		sw_cmd <= 4'h3;
		settle();
		chk_mode(4'h2);
		`CHK(halt, 1'h1)
		$display("restore and running test done");
		final_report();
	end

	// Whole run is a few hundred cycles; this leaves wide margin
	initial
	begin
		#100000;
		err_total++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end
endmodule
